/* File: inc/led_port_pkg.sv */
/*
  Shared constants for the link indicator and port control register pair:
  register indices and byte addresses, field positions, reset values,
  blink timing and the control state encoding.
  Assumes a 32-bit APB with byte addressing, one register per word.
*/
package led_port_pkg;

  // Register indices as printed; the byte address is four times the index
  localparam logic [7:0] LED_CTRL_IDX = 8'h18;
  localparam logic [7:0] PORT_CTRL_IDX = 8'h19;
  localparam int ADDR_W = 12;
  localparam logic [11:0] LED_CTRL_ADDR = {2'h0, LED_CTRL_IDX, 2'h0};
  localparam logic [11:0] PORT_CTRL_ADDR = {2'h0, PORT_CTRL_IDX, 2'h0};

  // Led control fields
  localparam int LED_RATE_LSB = 9;
  localparam int LED_POL_BIT = 7;
  localparam int LED_OVR_BIT = 4;
  localparam int LED_FORCE_BIT = 1;
  localparam logic [15:0] LED_CTRL_RST = 16'h0480;
  localparam logic [1:0] LED_RATE_RST = 2'h2;
  localparam logic LED_POL_RST = 1'h1;

  // Port control fields
  localparam int PC_AUTOX_BIT = 15;
  localparam int PC_FORCEX_BIT = 14;
  localparam int PC_PAUSE_RX_BIT = 13;
  localparam int PC_PAUSE_TX_BIT = 12;
  localparam int PC_LINK_BIT = 11;
  localparam int PC_BYPASS_BIT = 7;
  localparam int PC_ADDR_LSB = 0;
  localparam logic [15:0] PORT_CTRL_RST = 16'h8000;
  localparam logic PC_AUTOX_RST = 1'h1;

  // Bit positions within the two advertised pause bits (11:10)
  localparam int ADV_PAUSE = 0;
  localparam int ADV_ASYM = 1;

  // Blink timing
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned BLINK_MS0 = 50;
  localparam int unsigned BLINK_MS1 = 100;
  localparam int unsigned BLINK_MS2 = 200;
  localparam int unsigned BLINK_MS3 = 500;
  localparam int BLINK_CNT_W = 25;

  typedef enum logic [1:0]
  {
    ST_LATCH = 2'h1,
    ST_RUN = 2'h2
  } ctrl_state_e;

endpackage

/* File: design/led_blink_gen.sv */
/*
  Blink and stretch generator for the link indicator: a half-period timer
  selected by the rate code, and a stretch flag that keeps the indicator
  blinking after activity until the dark half-period in progress, or else the next one, ends.
  Assumes activity is a pulse or level synchronous to core_clk.
*/
`timescale 1ns/100ps
module led_blink_gen
  import led_port_pkg::*;
#(
  parameter int unsigned CYC0 = BLINK_MS0 * CYC_PER_MS,
  parameter int unsigned CYC1 = BLINK_MS1 * CYC_PER_MS,
  parameter int unsigned CYC2 = BLINK_MS2 * CYC_PER_MS,
  parameter int unsigned CYC3 = BLINK_MS3 * CYC_PER_MS
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic [1:0] rateCode,
  input wire logic activity,
  input wire logic bypass,
  // Result
  output logic darkMask
);

  typedef struct packed
  {
    logic [BLINK_CNT_W-1:0] cnt;
    logic phase;
    logic stretch;
    logic dark;
  } blink_s;

  blink_s blink_r;
  blink_s blink_nxt;
  logic [BLINK_CNT_W-1:0] limit;

  function automatic logic [BLINK_CNT_W-1:0] rateLimit(input logic [1:0] code);
    case (code)
      2'h0: rateLimit = BLINK_CNT_W'(CYC0 - 1);
      2'h1: rateLimit = BLINK_CNT_W'(CYC1 - 1);
      2'h2: rateLimit = BLINK_CNT_W'(CYC2 - 1);
      default: rateLimit = BLINK_CNT_W'(CYC3 - 1);
    endcase
  endfunction

  always_comb
  begin
    limit = rateLimit(rateCode);
    blink_nxt = blink_r;
    // A rate change mid-period wraps at once rather than running long
    if (blink_r.cnt >= limit)
    begin
      blink_nxt.cnt = '0;
      blink_nxt.phase = ~blink_r.phase;
      if (blink_r.phase)
      begin
        blink_nxt.stretch = 1'b0;
      end
    end
    else
    begin
      blink_nxt.cnt = blink_r.cnt + 1'b1;
    end
    if (activity)
    begin
      blink_nxt.stretch = 1'b1;
    end
    blink_nxt.dark = bypass ? activity : (blink_r.stretch & blink_r.phase);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      blink_r <= '0;
    end
    else
    begin
      blink_r <= blink_nxt;
    end
  end

  assign darkMask = blink_r.dark;

endmodule

/* File: design/led_and_port_control_regs.sv */
/*
  Link indicator control and port control registers behind an APB slave.
  Drives the link indicator pin, crossover controls, negotiated pause
  enables for the MAC and the management port address.
  Assumes straps are stable at reset release and all status inputs are
  synchronous to core_clk; APB is zero wait state.
*/
// The APB register port was decided locally.
// Functional notes
// - The blink rate code selects 50, 100, 200 or 500 ms on/off and resets to 2.
// - Link polarity bit 7 starts from the strap and software can override it.
// - With the override bit set the pin carries the forced level, else normal indication.
// - The force level bit gives the pin level during override, resetting to low.
// - Auto crossover enable defaults on in common_pinout_mode mode and follows its strap in enhanced mode.
// - Forced crossover swaps pairs and comes from its strap in enhanced mode with auto off.
// - Link status reads 1 only for an auto-negotiated 100 Mb full-duplex link.
// - Stretch bypass makes the indicator follow the raw status without stretching.
// - The port address field is latched from the strap pins in both pin modes.
// - Led control sits at index 0x18 and resets to 0x480.
// - Port control sits at index 0x19 and resets to 0x8000.
`timescale 1ns/100ps
module led_and_port_control_regs
  import led_port_pkg::*;
#(
  parameter int unsigned BLINK_CYC0 = BLINK_MS0 * CYC_PER_MS,
  parameter int unsigned BLINK_CYC1 = BLINK_MS1 * CYC_PER_MS,
  parameter int unsigned BLINK_CYC2 = BLINK_MS2 * CYC_PER_MS,
  parameter int unsigned BLINK_CYC3 = BLINK_MS3 * CYC_PER_MS
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [led_port_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Straps
  input wire logic enhancedMode,
  input wire logic strapLinkPolarity,
  input wire logic strapAutoCrossover,
  input wire logic strapForcedCrossover,
  input wire logic [4:0] strapPortAddress,
  // Link status
  input wire logic linkUp,
  input wire logic linkActivity,
  input wire logic speed100,
  input wire logic fullDuplex,
  input wire logic anComplete,
  input wire logic hcdFullDuplex,
  input wire logic [1:0] localAdvertPause,
  input wire logic [1:0] partnerAdvertPause,
  // Controls out
  output logic linkIndicatorPin,
  output logic autoCrossoverEnable,
  output logic forcedCrossover,
  output logic pauseRxEnable,
  output logic pauseTxEnable,
  output logic [4:0] managementPortAddress
);

  typedef struct packed
  {
    ctrl_state_e state;
    logic [1:0] blinkRate;
    logic linkPolarity;
    logic linkOverride;
    logic forceLevel;
    logic autoCross;
    logic forceCross;
    logic stretchBypass;
    logic [4:0] portAddr;
    logic pauseRx;
    logic pauseTx;
    logic miiLink;
    logic pin;
    logic [31:0] rdata;
    logic ready;
    logic slvErr;
  } ctrl_s;

  localparam ctrl_s CTRL_RST = '{
    state: ST_LATCH,
    blinkRate: LED_RATE_RST,
    linkPolarity: LED_POL_RST,
    linkOverride: 1'h0,
    forceLevel: 1'h0,
    autoCross: PC_AUTOX_RST,
    forceCross: 1'h0,
    stretchBypass: 1'h0,
    portAddr: 5'h00,
    pauseRx: 1'h0,
    pauseTx: 1'h0,
    miiLink: 1'h0,
    pin: 1'h0,
    rdata: 32'h00000000,
    ready: 1'h0,
    slvErr: 1'h0
  };

  ctrl_s ctrl_r;
  ctrl_s ctrl_nxt;
  logic darkMask;
  logic [1:0] setupHit;
  logic [1:0] accessHit;
  logic setupPhase;
  logic writeTaken;
  logic [15:0] ledWr;
  logic [15:0] portWr;
  logic [1:0] pauseRes;
  logic level;

  // One-hot register select: bit 0 led control, bit 1 port control
  function automatic logic [1:0] regHit(input logic [ADDR_W-1:0] addr);
    regHit = {addr == PORT_CTRL_ADDR, addr == LED_CTRL_ADDR};
  endfunction

  function automatic logic [15:0] ledWord(input ctrl_s s);
    ledWord = 16'h0000;
    ledWord[LED_RATE_LSB +: 2] = s.blinkRate;
    ledWord[LED_POL_BIT] = s.linkPolarity;
    ledWord[LED_OVR_BIT] = s.linkOverride;
    ledWord[LED_FORCE_BIT] = s.forceLevel;
  endfunction

  function automatic logic [15:0] portWord(input ctrl_s s);
    portWord = 16'h0000;
    portWord[PC_AUTOX_BIT] = s.autoCross;
    portWord[PC_FORCEX_BIT] = s.forceCross;
    portWord[PC_PAUSE_RX_BIT] = s.pauseRx;
    portWord[PC_PAUSE_TX_BIT] = s.pauseTx;
    portWord[PC_LINK_BIT] = s.miiLink;
    portWord[PC_BYPASS_BIT] = s.stretchBypass;
    portWord[PC_ADDR_LSB +: 5] = s.portAddr;
  endfunction

  // Byte lanes 0 and 1 carry the 16-bit register; upper lanes are unused
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] strb);
    merge = old;
    if (strb[0])
    begin
      merge[7:0] = wd[7:0];
    end
    if (strb[1])
    begin
      merge[15:8] = wd[15:8];
    end
  endfunction

  // Returns {tx, rx} from local and partner {asym, pause}
  function automatic logic [1:0] pauseResolve(input logic [1:0] loc,
                                              input logic [1:0] par);
    pauseResolve = 2'h0;
    if (loc[ADV_PAUSE] && par[ADV_PAUSE])
    begin
      pauseResolve = 2'h3;
    end
    else if (loc[ADV_PAUSE] && loc[ADV_ASYM] && par[ADV_ASYM])
    begin
      pauseResolve = 2'h1;
    end
    else if (!loc[ADV_PAUSE] && loc[ADV_ASYM] && par[ADV_PAUSE] && par[ADV_ASYM])
    begin
      pauseResolve = 2'h2;
    end
  endfunction

  led_blink_gen #(
    .CYC0(BLINK_CYC0),
    .CYC1(BLINK_CYC1),
    .CYC2(BLINK_CYC2),
    .CYC3(BLINK_CYC3)
  ) led_blink_gen_i (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .rateCode(ctrl_r.blinkRate),
    .activity(linkActivity),
    .bypass(ctrl_r.stretchBypass),
    .darkMask(darkMask)
  );

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    setupPhase = psel && !penable;
    setupHit = regHit(paddr);
    accessHit = regHit(paddr);
    // Write lands at the edge where the master sees pready high
    writeTaken = psel && penable && pwrite && ctrl_r.ready;
    ledWr = merge(ledWord(ctrl_r), pwdata, pstrb);
    portWr = merge(portWord(ctrl_r), pwdata, pstrb);
    pauseRes = pauseResolve(localAdvertPause, partnerAdvertPause);

    // APB answer is prepared in setup so the outputs come from flops
    ctrl_nxt.ready = setupPhase;
    ctrl_nxt.slvErr = setupPhase && (setupHit == 2'h0);
    if (setupPhase && !pwrite)
    begin
      case (setupHit)
        2'h1: ctrl_nxt.rdata = {16'h0000, ledWord(ctrl_r)};
        2'h2: ctrl_nxt.rdata = {16'h0000, portWord(ctrl_r)};
        default: ctrl_nxt.rdata = 32'h00000000;
      endcase
    end
    else if (!psel || setupPhase)
    begin
      // Write setups clear it too, so a refused write never shows stale data
      ctrl_nxt.rdata = 32'h00000000;
    end

    case (ctrl_r.state)
      ST_LATCH:
      begin
        // First cycle after release: catch the straps
        ctrl_nxt.linkPolarity = strapLinkPolarity;
        ctrl_nxt.portAddr = strapPortAddress;
        if (enhancedMode)
        begin
          ctrl_nxt.autoCross = strapAutoCrossover;
          ctrl_nxt.forceCross = !strapAutoCrossover && strapForcedCrossover;
        end
        else
        begin
          ctrl_nxt.autoCross = PC_AUTOX_RST;
          ctrl_nxt.forceCross = 1'b0;
        end
        ctrl_nxt.state = ST_RUN;
      end
      ST_RUN:
      begin
        if (writeTaken && accessHit[0])
        begin
          ctrl_nxt.blinkRate = ledWr[LED_RATE_LSB +: 2];
          ctrl_nxt.linkPolarity = ledWr[LED_POL_BIT];
          ctrl_nxt.linkOverride = ledWr[LED_OVR_BIT];
          ctrl_nxt.forceLevel = ledWr[LED_FORCE_BIT];
        end
        if (writeTaken && accessHit[1])
        begin
          ctrl_nxt.autoCross = portWr[PC_AUTOX_BIT];
          ctrl_nxt.forceCross = portWr[PC_FORCEX_BIT];
          ctrl_nxt.stretchBypass = portWr[PC_BYPASS_BIT];
        end
      end
      default:
      begin
        ctrl_nxt.state = ST_RUN;
      end
    endcase

    // Status bits are read-only; writes never reach them
    ctrl_nxt.pauseRx = hcdFullDuplex && pauseRes[0];
    ctrl_nxt.pauseTx = hcdFullDuplex && pauseRes[1];
    ctrl_nxt.miiLink = linkUp && speed100 && fullDuplex && anComplete;

    // Blink darkens the lit level; polarity then maps to the pin
    level = linkUp && !darkMask;
    if (ctrl_r.linkOverride)
    begin
      ctrl_nxt.pin = ctrl_r.forceLevel;
    end
    else
    begin
      ctrl_nxt.pin = ctrl_r.linkPolarity ? level : !level;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ctrl_r <= CTRL_RST;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign prdata = ctrl_r.rdata;
  assign pready = ctrl_r.ready;
  assign pslverr = ctrl_r.slvErr;
  assign linkIndicatorPin = ctrl_r.pin;
  assign autoCrossoverEnable = ctrl_r.autoCross;
  assign forcedCrossover = ctrl_r.forceCross;
  assign pauseRxEnable = ctrl_r.pauseRx;
  assign pauseTxEnable = ctrl_r.pauseTx;
  assign managementPortAddress = ctrl_r.portAddr;

endmodule

/* File: testbench/led_port_asserts.sv */
/*
  Port-level checker for the link indicator and port control registers.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module led_port_asserts
  import led_port_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [led_port_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Straps and status
  input wire logic [4:0] strapPortAddress,
  input wire logic hcdFullDuplex,
  input wire logic [1:0] localAdvertPause,
  input wire logic [1:0] partnerAdvertPause,
  // Outputs
  input wire logic linkIndicatorPin,
  input wire logic autoCrossoverEnable,
  input wire logic forcedCrossover,
  input wire logic pauseRxEnable,
  input wire logic pauseTxEnable,
  input wire logic [4:0] managementPortAddress
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire mapped = paddr == LED_CTRL_ADDR || paddr == PORT_CTRL_ADDR;
  wire setup = psel && !penable;
  wire ovrWrite = psel && penable && pready && pwrite && paddr == LED_CTRL_ADDR && pstrb[0];

  a_ready_single: assert property (setup |=> pready ##1 !pready)
    else $error("ready not a single cycle after setup");
  a_unmapped_err: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_clean: assert property (setup && mapped |=> !pslverr && prdata[31:16] == 16'h0)
    else $error("mapped access flagged or upper data set");
  // Own disable: the reset itself is the cause here
  a_reset_values: assert property (disable iff (1'h0) !rst_n |=> autoCrossoverEnable
    && !forcedCrossover && !pauseRxEnable && !pauseTxEnable && managementPortAddress == 5'h00)
    else $error("outputs wrong during reset");
  a_pause_gated: assert property (!hcdFullDuplex |=> !pauseRxEnable && !pauseTxEnable)
    else $error("pause set without full duplex");
  a_pause_both: assert property (hcdFullDuplex && localAdvertPause[0]
    && partnerAdvertPause[0] |=> pauseRxEnable && pauseTxEnable)
    else $error("symmetric pause not resolved");
  a_pause_rx_only: assert property (hcdFullDuplex && localAdvertPause == 2'h3
    && partnerAdvertPause == 2'h2 |=> pauseRxEnable && !pauseTxEnable)
    else $error("receive-only pause not resolved");
  a_pause_tx_only: assert property (hcdFullDuplex && localAdvertPause == 2'h2
    && partnerAdvertPause == 2'h3 |=> !pauseRxEnable && pauseTxEnable)
    else $error("transmit-only pause not resolved");
  a_addr_latch: assert property ($past(rst_n) && !$past(rst_n, 2)
    |-> managementPortAddress == $past(strapPortAddress))
    else $error("port address not taken from strap");
  a_addr_hold: assert property ($past(rst_n) && $past(rst_n, 2) |-> $stable(managementPortAddress))
    else $error("port address changed after latch");
  a_override_level: assert property (ovrWrite && pwdata[LED_OVR_BIT]
    |-> ##2 linkIndicatorPin == $past(pwdata[LED_FORCE_BIT], 2))
    else $error("pin not at forced level");

  c_refused: cover property (setup && !mapped ##1 pslverr);
  c_rx_only: cover property (pauseRxEnable && !pauseTxEnable);
  c_forced_high: cover property (ovrWrite && pwdata[LED_OVR_BIT] ##2 linkIndicatorPin);
endmodule

bind led_and_port_control_regs led_port_asserts led_port_asserts_i (.core_clk, .rst_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .strapPortAddress,
  .hcdFullDuplex, .localAdvertPause, .partnerAdvertPause, .linkIndicatorPin,
  .autoCrossoverEnable, .forcedCrossover, .pauseRxEnable, .pauseTxEnable,
  .managementPortAddress);

/* File: testbench/led_and_port_control_regs_test.sv */
/*
  Self-checking bench for the link indicator and port control registers.
  Assumes zero-wait APB and shortened blink counts of 8/16/32/80 cycles.
*/
`timescale 1ns/100ps
module led_and_port_control_regs_test;
  import led_port_pkg::*;
  localparam int CYC [4] = '{8, 16, 32, 80};
  logic core_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, err, linkIndicatorPin, autoCrossoverEnable, forcedCrossover;
  logic enhancedMode = 1'h1, strapLinkPolarity = 1'h1, strapAutoCrossover = 1'h1;
  logic strapForcedCrossover = 1'h0, linkUp = 1'h0, linkActivity = 1'h0, speed100 = 1'h0;
  logic fullDuplex = 1'h0, anComplete = 1'h0, hcdFullDuplex = 1'h0;
  logic pauseRxEnable, pauseTxEnable;
  logic [1:0] localAdvertPause = 2'h0, partnerAdvertPause = 2'h0;
  logic [4:0] strapPortAddress = 5'h05, managementPortAddress;
  int nErrors = 0, checkCount = 0;

  led_and_port_control_regs #(.BLINK_CYC0(8), .BLINK_CYC1(16), .BLINK_CYC2(32), .BLINK_CYC3(80))
  led_and_port_control_regs_i (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .enhancedMode, .strapLinkPolarity, .strapAutoCrossover,
    .strapForcedCrossover, .strapPortAddress, .linkUp, .linkActivity, .speed100, .fullDuplex,
    .anComplete, .hcdFullDuplex, .localAdvertPause, .partnerAdvertPause, .linkIndicatorPin,
    .autoCrossoverEnable, .forcedCrossover, .pauseRxEnable, .pauseTxEnable,
    .managementPortAddress);

  initial
  begin
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", nErrors, checkCount);
    if (nErrors == 0 && checkCount > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp)
    begin
      nErrors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Values read before the edge's updates land are those sampled at that edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [15:0] d,
                     input logic [3:0] s = 4'hF);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'h1;
    do
      @(posedge core_clk);
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'h0, 16'h0);
    chk(what, exp, rd);
  endtask

  task automatic pin(input string what, input logic exp);
    repeat (3) @(posedge core_clk);
    chk(what, {31'h0, exp}, {31'h0, linkIndicatorPin});
  endtask

  task automatic boot(input logic enh, input logic pol, input logic ax, input logic fx);
    enhancedMode <= enh;
    strapLinkPolarity <= pol;
    strapAutoCrossover <= ax;
    strapForcedCrossover <= fx;
    rst_n <= 1'h0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge core_clk);
  endtask

  // Skips two toggles so a rate change mid-count cannot skew the measure
  task automatic halfper(input int c);
    int n;
    logic p;
    for (int k = 0; k < 2; k++)
    begin
      p = linkIndicatorPin;
      while (linkIndicatorPin === p) @(posedge core_clk);
    end
    p = linkIndicatorPin;
    n = 0;
    while (linkIndicatorPin === p)
    begin
      @(posedge core_clk);
      n++;
    end
    chk("half period", CYC[c], n);
  endtask

  function automatic logic [31:0] pauseExp(input logic [4:0] v);
    logic [1:0] l;
    logic [1:0] p;
    l = v[3:2];
    p = v[1:0];
    return {30'h0, v[4] & (l[0] & p[0] | l == 2'h2 & p == 2'h3),
      v[4] & (l[0] & p[0] | l == 2'h3 & p == 2'h2)};
  endfunction

  initial
  begin
    repeat (20000) @(posedge core_clk);
    nErrors++;
    conclude();
  end

  initial
  begin
    boot(1'h1, 1'h1, 1'h1, 1'h0);
    rdchk("led reset", LED_CTRL_ADDR, 32'h480);
    chk("mapped error", 32'h0, {31'h0, err});
    rdchk("port reset", PORT_CTRL_ADDR, 32'h8005);
    rdchk("unmapped data", 12'h068, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(LED_CTRL_ADDR, 1'h1, 16'hFFFF);
    pin("forced high", 1'h1);
    rdchk("led fields", LED_CTRL_ADDR, 32'h692);
    apb(LED_CTRL_ADDR, 1'h1, 16'h0010);
    pin("forced low", 1'h0);
    apb(LED_CTRL_ADDR, 1'h1, 16'hFFFF, 4'h2);
    rdchk("upper lane only", LED_CTRL_ADDR, 32'h610);
    apb(PORT_CTRL_ADDR, 1'h1, 16'hFFFF);
    rdchk("port fields", PORT_CTRL_ADDR, 32'hC085);
    chk("crossover", 32'h3, {30'h0, autoCrossoverEnable, forcedCrossover});
    linkUp <= 1'h1;
    apb(LED_CTRL_ADDR, 1'h1, 16'h0080);
    pin("active high", 1'h1);
    apb(LED_CTRL_ADDR, 1'h1, 16'h0000);
    pin("active low", 1'h0);
    apb(LED_CTRL_ADDR, 1'h1, 16'h0080);
    linkActivity <= 1'h1;
    pin("bypass dark", 1'h0);
    apb(PORT_CTRL_ADDR, 1'h1, 16'h8000);
    for (int c = 0; c < 4; c++)
    begin
      apb(LED_CTRL_ADDR, 1'h1, {5'h00, 2'(c), 9'h080});
      halfper(c);
    end
    {speed100, fullDuplex, anComplete} <= 3'h7;
    repeat (3) @(posedge core_clk);
    rdchk("link status", PORT_CTRL_ADDR, 32'h8805);
    anComplete <= 1'h0;
    repeat (3) @(posedge core_clk);
    rdchk("link not negotiated", PORT_CTRL_ADDR, 32'h8005);
    for (int i = 0; i < 32; i++)
    begin
      {hcdFullDuplex, localAdvertPause, partnerAdvertPause} <= 5'(i);
      repeat (3) @(posedge core_clk);
      chk("pause", pauseExp(5'(i)), {30'h0, pauseTxEnable, pauseRxEnable});
    end
    rdchk("pause bits", PORT_CTRL_ADDR, 32'hB005);
    boot(1'h0, 1'h0, 1'h0, 1'h1);
    chk("common_pinout_mode crossover", 32'h2, {30'h0, autoCrossoverEnable, forcedCrossover});
    chk("address", 32'h5, {27'h0, managementPortAddress});
    rdchk("led strap", LED_CTRL_ADDR, 32'h400);
    boot(1'h1, 1'h1, 1'h0, 1'h1);
    chk("enhanced crossover", 32'h1, {30'h0, autoCrossoverEnable, forcedCrossover});
    conclude();
  end
endmodule
